// >>> common/dscac_pkg.sv
package dscac_pkg;
	// Debug register byte offsets inside the 4KB window
	localparam logic [11:0] STATUS_OFF  = 12'h088;
	localparam logic [11:0] RUN_OFF     = 12'h090;
	localparam logic [11:0] CACHE_OFF   = 12'h028;
	// Status and control field positions
	localparam int ST_HALTED     = 0;
	localparam int ST_RESTARTED  = 1;
	localparam int ST_METHOD_LO  = 2;
	localparam int ST_PRECISE    = 6;
	localparam int ST_IMPRECISE  = 7;
	localparam int ST_FORCED_ACK = 11;
	// Run control field positions
	localparam int RUN_HALT      = 0;
	localparam int RUN_RESTART   = 1;
	localparam int RUN_CLR_STICKY = 2;
	// Halted cache control field positions and reset value
	localparam int CC_FILL_EVICT = 0;
	localparam int CC_WRITE_BACK = 2;
	localparam logic [2:0] CACHE_RESET = 3'h5;
	// Entry method codes
	localparam logic [3:0] METHOD_DEBUGGER = 4'h0;
	localparam logic [3:0] METHOD_EXTERNAL = 4'h4;
	localparam logic [3:0] METHOD_WATCH    = 4'hA;
	// Controller register byte offsets (AXI4-Lite)
	localparam logic [3:0] CTL_CMD_OFF    = 4'h0;
	localparam logic [3:0] CTL_WDATA_OFF  = 4'h4;
	localparam logic [3:0] CTL_STATUS_OFF = 4'h8;
	localparam logic [3:0] CTL_RDATA_OFF  = 4'hC;
	// Command register field positions
	localparam int CMD_WRITE  = 12;
	localparam int CMD_SOURCE = 13;
	// AXI response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> common/dscac_apb_if.sv
`timescale 1ns/1ns
`default_nettype none
interface dscac_apb_if;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:2] paddr;
	logic        paddr31;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	modport dev (input psel, penable, pwrite, paddr, paddr31, pwdata,
		output prdata, pready, pslverr);
	modport dbg (output psel, penable, pwrite, paddr, paddr31, pwdata,
		input prdata, pready, pslverr);
endinterface
`default_nettype wire

// >>> src/dscac_device.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// - precise abort halted: sticky flag, fault update
// - imprecise abort halted: sticky flag, no entry
// - imprecise abort while halted is discarded
// - entry barrier abort recorded as pending
// - discarding keeps recorded application abort
// - debugger runs barrier before restart
// - after exit pending abort obeys mask
// - watchpoint wins, imprecise abort kept pending
// - restart from run control or trigger
// - clear restarted, leave, clear halted
// - acknowledge low unless forced bit set
// - resume fetch and set restarted in the same cycle
// - debugger access keeps cache except write hit
// - halted, bit0 zero: no fill or evict
// - alias on bit 12 still evicts
// - hash collision still evicts
// - halted, bit2 zero: write-through
// - halted permits instruction cache invalidates
// - halted branch buffer flush is no-op
// - nonsecure invalidate-all drops both worlds
// - APB slave, waits, errors, bits 11:2
// - master drives source bit 31
// - acknowledge once debug state entered
module dscac_device (
	// Clock, reset, enable
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic ce,
	// Debug register port
	dscac_apb_if.dev  apb,
	// Pins from outside the clock domain
	input  wire logic external_halt_request,
	input  wire logic cross_trigger_restart,
	// Core events
	input  wire logic watchpoint_hit,
	input  wire logic precise_abort,
	input  wire logic imprecise_abort,
	input  wire logic entry_barrier_abort,
	input  wire logic abort_mask,
	// Cache and maintenance requests
	input  wire logic debug_access,
	input  wire logic debug_write,
	input  wire logic cache_hit,
	input  wire logic alias_conflict,
	input  wire logic hash_conflict,
	input  wire logic icache_inval_all,
	input  wire logic icache_inval_line,
	input  wire logic btb_flush,
	input  wire logic privileged,
	input  wire logic nonsecure,
	// Core control
	output logic      halted,
	output logic      halt_acknowledge,
	output logic      resume_fetch,
	output logic      fault_status_update,
	output logic      take_imprecise_abort,
	// Cache control
	output logic      cache_state_hold,
	output logic      suppress_fill_evict,
	output logic      evict_to_l2,
	output logic      force_write_through,
	output logic      icache_inval_do,
	output logic      inval_both_worlds,
	output logic      btb_flush_nop
);
	typedef enum logic [1:0] {S_RUN, S_HALT, S_LEAVE, S_RESUME} dscac_state_t;

	dscac_state_t state_reg;
	logic         ehr_s1_reg;
	logic         ehr_s2_reg;
	logic         ctr_s1_reg;
	logic         ctr_s2_reg;
	logic         wait_reg;
	logic         restarted_reg;
	logic         precise_reg;
	logic         imprecise_reg;
	logic         forced_ack_reg;
	logic [3:0]   method_reg;
	logic [2:0]   cache_reg;
	logic         pending_reg;
	logic [31:0]  prdata_reg;
	logic         slverr_reg;
	logic         acc;
	logic         done;
	logic         sel_status;
	logic         sel_run;
	logic         sel_cache;
	logic         unmapped;
	logic         wr;
	logic         halt_wr;
	logic         restart_wr;
	logic         clr_sticky;
	logic         halt_cause;
	logic         restart_req;
	logic         in_debug;
	logic [31:0]  status_word;

	// Two-flop synchronisers for the pins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ehr_s1_reg <= 1'b0;
			ehr_s2_reg <= 1'b0;
			ctr_s1_reg <= 1'b0;
			ctr_s2_reg <= 1'b0;
		end
		else if (ce)
		begin
			ehr_s1_reg <= external_halt_request;
			ehr_s2_reg <= ehr_s1_reg;
			ctr_s1_reg <= cross_trigger_restart;
			ctr_s2_reg <= ctr_s1_reg;
		end
	end

	// One wait state in every access phase
	assign acc         = apb.psel & apb.penable;
	assign done        = acc & wait_reg;
	assign apb.pready  = done;
	assign apb.prdata  = prdata_reg;
	assign apb.pslverr = slverr_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			wait_reg <= 1'b0;
		else if (ce)
			wait_reg <= acc & !wait_reg;
	end

	always_comb
	begin
		sel_status = 1'b0;
		sel_run    = 1'b0;
		sel_cache  = 1'b0;
		unmapped   = 1'b0;
		if (apb.paddr == dscac_pkg::STATUS_OFF[11:2])
			sel_status = 1'b1;
		else if (apb.paddr == dscac_pkg::RUN_OFF[11:2])
			sel_run = 1'b1;
		else if (apb.paddr == dscac_pkg::CACHE_OFF[11:2])
			sel_cache = 1'b1;
		else
			unmapped = 1'b1;
	end

	assign wr          = done & apb.pwrite & !unmapped;
	assign halt_wr     = wr & sel_run & apb.pwdata[dscac_pkg::RUN_HALT];
	assign restart_wr  = wr & sel_run & apb.pwdata[dscac_pkg::RUN_RESTART];
	assign clr_sticky  = wr & sel_run & apb.pwdata[dscac_pkg::RUN_CLR_STICKY];
	assign halt_cause  = ehr_s2_reg | watchpoint_hit | halt_wr;
	assign restart_req = restart_wr | ctr_s2_reg;
	assign in_debug    = state_reg != S_RUN;

	always_comb
	begin
		status_word = 32'h0000_0000;
		status_word[dscac_pkg::ST_HALTED] = halted;
		status_word[dscac_pkg::ST_RESTARTED] = restarted_reg;
		status_word[dscac_pkg::ST_METHOD_LO +: 4] = method_reg;
		status_word[dscac_pkg::ST_PRECISE] = precise_reg;
		status_word[dscac_pkg::ST_IMPRECISE] = imprecise_reg;
		status_word[dscac_pkg::ST_FORCED_ACK] = forced_ack_reg;
	end

	// Read data and error answer
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			prdata_reg <= 32'h0000_0000;
			slverr_reg <= 1'b0;
		end
		else if (ce && acc && !wait_reg)
		begin
			slverr_reg <= unmapped;
			if (sel_status)
				prdata_reg <= status_word;
			else if (sel_cache)
				prdata_reg <= {29'h0000_0000, cache_reg};
			else
				prdata_reg <= 32'h0000_0000;
		end
	end

	// Writable control bits
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			forced_ack_reg <= 1'b0;
			cache_reg      <= dscac_pkg::CACHE_RESET;
		end
		else if (ce && wr)
		begin
			if (sel_status)
				forced_ack_reg <= apb.pwdata[dscac_pkg::ST_FORCED_ACK];
			if (sel_cache)
				cache_reg <= apb.pwdata[2:0];
		end
	end

	// Debug state sequencing
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg     <= S_RUN;
			halted        <= 1'b0;
			restarted_reg <= 1'b1;
			method_reg    <= dscac_pkg::METHOD_DEBUGGER;
			resume_fetch  <= 1'b0;
		end
		else if (ce)
		begin
			resume_fetch <= 1'b0;
			case (state_reg)
				S_RUN:
					if (halt_cause)
					begin
						state_reg <= S_HALT;
						halted    <= 1'b1;
						if (watchpoint_hit)
							method_reg <= dscac_pkg::METHOD_WATCH;
						else if (ehr_s2_reg)
							method_reg <= dscac_pkg::METHOD_EXTERNAL;
						else
							method_reg <= dscac_pkg::METHOD_DEBUGGER;
					end
				S_HALT:
					if (restart_req)
					begin
						restarted_reg <= 1'b0;
						state_reg     <= S_LEAVE;
					end
				S_LEAVE:
				begin
					halted    <= 1'b0;
					state_reg <= S_RESUME;
				end
				default:
				begin
					resume_fetch  <= 1'b1;
					restarted_reg <= 1'b1;
					state_reg     <= S_RUN;
				end
			endcase
		end
	end

	// Acknowledge follows entry, drops after halted clears
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			halt_acknowledge <= 1'b0;
		else if (ce)
		begin
			if (state_reg == S_RUN && halt_cause)
				halt_acknowledge <= 1'b1;
			else if (state_reg == S_RUN || state_reg == S_RESUME)
				halt_acknowledge <= forced_ack_reg;
		end
	end

	// Sticky flags, set wins over clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			precise_reg   <= 1'b0;
			imprecise_reg <= 1'b0;
		end
		else if (ce)
		begin
			if (in_debug && precise_abort)
				precise_reg <= 1'b1;
			else if (clr_sticky)
				precise_reg <= 1'b0;
			if (in_debug && imprecise_abort)
				imprecise_reg <= 1'b1;
			else if (clr_sticky)
				imprecise_reg <= 1'b0;
		end
	end

	// Recorded imprecise abort and abort outputs
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pending_reg          <= 1'b0;
			take_imprecise_abort <= 1'b0;
			fault_status_update  <= 1'b0;
		end
		else if (ce)
		begin
			take_imprecise_abort <= 1'b0;
			// Same as normal state; no pc or status change halted
			fault_status_update  <= precise_abort;
			if (state_reg == S_RUN)
			begin
				if (halt_cause)
				begin
					if (entry_barrier_abort || imprecise_abort)
						pending_reg <= 1'b1;
				end
				else if ((pending_reg || imprecise_abort) && !abort_mask)
				begin
					take_imprecise_abort <= 1'b1;
					pending_reg          <= 1'b0;
				end
				else if (imprecise_abort)
					pending_reg <= 1'b1;
			end
			// Halted aborts leave pending_reg alone
		end
	end

	// Cache behaviour in debug state
	assign cache_state_hold    = in_debug & debug_access & !(debug_write & cache_hit);
	assign suppress_fill_evict = in_debug & !cache_reg[dscac_pkg::CC_FILL_EVICT];
	assign evict_to_l2         = alias_conflict | hash_conflict;
	assign force_write_through = in_debug & !cache_reg[dscac_pkg::CC_WRITE_BACK];
	assign icache_inval_do     = (icache_inval_all | icache_inval_line)
		& (privileged | in_debug);
	assign inval_both_worlds   = icache_inval_all & nonsecure;
	assign btb_flush_nop       = btb_flush & (privileged | in_debug);
endmodule
`default_nettype wire

// >>> src/dscac_debugger.sv
`timescale 1ns/1ns
`default_nettype none
module dscac_debugger (
	// Clock, reset, enable
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	// AXI4-Lite write
	input  wire logic [3:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic [3:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Barrier handshake with the halted core
	output logic             sync_barrier_req,
	input  wire logic        sync_barrier_done,
	// Debug register port
	dscac_apb_if.dbg         apb
);
	typedef enum logic [1:0] {M_IDLE, M_BARRIER, M_SETUP, M_ACCESS} dscac_mstate_t;

	dscac_mstate_t mstate_reg;
	logic          aw_held_reg;
	logic [3:0]    aw_addr_reg;
	logic          w_held_reg;
	logic [31:0]   w_data_reg;
	logic [13:0]   cmd_reg;
	logic [31:0]   wdata_reg;
	logic [31:0]   rdata_reg;
	logic          slverr_reg;
	logic          busy;
	logic          do_write;
	logic          start;
	logic          restart_cmd;

	assign busy     = mstate_reg != M_IDLE;
	assign awready  = !aw_held_reg;
	assign wready   = !w_held_reg;
	assign arready  = !rvalid;
	assign do_write = aw_held_reg & w_held_reg & !bvalid;
	assign start    = do_write & (aw_addr_reg == dscac_pkg::CTL_CMD_OFF) & !busy;

	// Write address and data taken in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			aw_addr_reg <= 4'h0;
			w_data_reg  <= 32'h0000_0000;
			bvalid      <= 1'b0;
			bresp       <= dscac_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			if (awvalid && awready)
			begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_held_reg <= 1'b1;
				w_data_reg <= wdata;
			end
			if (do_write)
			begin
				bvalid <= 1'b1;
				bresp  <= (aw_addr_reg == dscac_pkg::CTL_CMD_OFF && busy) ?
					dscac_pkg::RESP_SLVERR : dscac_pkg::RESP_OKAY;
			end
			else if (bvalid && bready)
			begin
				bvalid      <= 1'b0;
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
			end
		end
	end

	// Command and data registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cmd_reg   <= 14'h0000;
			wdata_reg <= 32'h0000_0000;
		end
		else if (ce && do_write)
		begin
			if (start)
				cmd_reg <= w_data_reg[13:0];
			else if (aw_addr_reg == dscac_pkg::CTL_WDATA_OFF && wstrb != 4'h0)
				wdata_reg <= w_data_reg;
		end
	end

	// Register reads
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= dscac_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			if (arvalid && arready)
			begin
				rvalid <= 1'b1;
				rresp  <= dscac_pkg::RESP_OKAY;
				if (araddr == dscac_pkg::CTL_CMD_OFF)
					rdata <= {18'h0_0000, cmd_reg};
				else if (araddr == dscac_pkg::CTL_WDATA_OFF)
					rdata <= wdata_reg;
				else if (araddr == dscac_pkg::CTL_STATUS_OFF)
					rdata <= {30'h0000_0000, slverr_reg, busy};
				else if (araddr == dscac_pkg::CTL_RDATA_OFF)
					rdata <= rdata_reg;
				else
				begin
					rdata <= 32'h0000_0000;
					rresp <= dscac_pkg::RESP_SLVERR;
				end
			end
			else if (rvalid && rready)
				rvalid <= 1'b0;
		end
	end

	assign restart_cmd = w_data_reg[dscac_pkg::CMD_WRITE]
		& (w_data_reg[11:2] == dscac_pkg::RUN_OFF[11:2])
		& wdata_reg[dscac_pkg::RUN_RESTART];

	// APB master sequence
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mstate_reg       <= M_IDLE;
			sync_barrier_req <= 1'b0;
			apb.psel         <= 1'b0;
			apb.penable      <= 1'b0;
			apb.pwrite       <= 1'b0;
			apb.paddr        <= 10'h000;
			apb.paddr31      <= 1'b0;
			apb.pwdata       <= 32'h0000_0000;
			rdata_reg        <= 32'h0000_0000;
			slverr_reg       <= 1'b0;
		end
		else if (ce)
		begin
			case (mstate_reg)
				M_IDLE:
					if (start)
					begin
						apb.pwrite  <= w_data_reg[dscac_pkg::CMD_WRITE];
						apb.paddr   <= w_data_reg[11:2];
						apb.paddr31 <= w_data_reg[dscac_pkg::CMD_SOURCE];
						apb.pwdata  <= wdata_reg;
						if (restart_cmd)
						begin
							sync_barrier_req <= 1'b1;
							mstate_reg       <= M_BARRIER;
						end
						else
						begin
							apb.psel   <= 1'b1;
							mstate_reg <= M_SETUP;
						end
					end
				M_BARRIER:
					if (sync_barrier_done)
					begin
						sync_barrier_req <= 1'b0;
						apb.psel         <= 1'b1;
						mstate_reg       <= M_SETUP;
					end
				M_SETUP:
				begin
					apb.penable <= 1'b1;
					mstate_reg  <= M_ACCESS;
				end
				default:
					if (apb.pready)
					begin
						apb.psel    <= 1'b0;
						apb.penable <= 1'b0;
						slverr_reg  <= apb.pslverr;
						if (!apb.pwrite)
							rdata_reg <= apb.prdata;
						mstate_reg <= M_IDLE;
					end
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> testbench/dscac_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module dscac_asserts (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Debug register port
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:2] paddr,
	input wire logic        paddr31,
	input wire logic        pready,
	// Core side
	input wire logic        halted,
	input wire logic        halt_acknowledge,
	input wire logic        resume_fetch,
	input wire logic        precise_abort,
	input wire logic        fault_status_update
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	apb_wait_a: assert property ($rose(penable) |-> !pready ##1 pready)
		else $error("pready not one wait state after penable");
	pready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	apb_setup_a: assert property (psel && !penable |=> psel && penable)
		else $error("setup phase not followed by access");
	apb_hold_a: assert property (psel && penable && !pready
		|=> $stable(paddr) && $stable(pwrite))
		else $error("address or direction changed in wait");
	src_stable_a: assert property (psel && penable |-> $stable(paddr31))
		else $error("source bit changed during access");
	ack_on_halt_a: assert property ($rose(halted) |-> halt_acknowledge)
		else $error("halt without acknowledge");
	exit_order_a: assert property ($fell(halted) |=> resume_fetch)
		else $error("fetch not resumed after halted cleared");
	fetch_run_a: assert property (resume_fetch |-> !halted && $past(halted, 2))
		else $error("fetch resumed at wrong point");
	fault_upd_a: assert property (precise_abort |=> fault_status_update)
		else $error("fault status not updated");
endmodule
`default_nettype wire

// >>> testbench/dscac_debug_state_abort_exit_cache_ctrl_test.sv
`timescale 1ns/1ns
`default_nettype none
module debug_state_abort_exit_cache_ctrl_test;
	logic        aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, sync_barrier_req, sync_barrier_done;
	logic [3:0]  awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, q;
	logic [1:0]  bresp, rresp;
	logic        external_halt_request, cross_trigger_restart, watchpoint_hit, precise_abort;
	logic        imprecise_abort, entry_barrier_abort, abort_mask, debug_access, debug_write;
	logic        cache_hit, alias_conflict, hash_conflict, icache_inval_all, icache_inval_line;
	logic        btb_flush, privileged, nonsecure, last_err;
	logic        halted, halt_acknowledge, resume_fetch, fault_status_update, take_imprecise_abort;
	logic        cache_state_hold, suppress_fill_evict, evict_to_l2, force_write_through;
	logic        icache_inval_do, inval_both_worlds, btb_flush_nop;
	int          fails, samples_checked, cycles, resumes, takes;

	dscac_apb_if apb_bus ();
	dscac_debugger dscac_debugger_inst (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .sync_barrier_req, .sync_barrier_done, .apb(apb_bus));
	dscac_device dscac_device_inst (.aclk, .aresetn, .ce, .apb(apb_bus), .external_halt_request,
		.cross_trigger_restart, .watchpoint_hit, .precise_abort, .imprecise_abort,
		.entry_barrier_abort, .abort_mask, .debug_access, .debug_write, .cache_hit,
		.alias_conflict, .hash_conflict, .icache_inval_all, .icache_inval_line, .btb_flush,
		.privileged, .nonsecure, .halted, .halt_acknowledge, .resume_fetch, .fault_status_update,
		.take_imprecise_abort, .cache_state_hold, .suppress_fill_evict, .evict_to_l2,
		.force_write_through, .icache_inval_do, .inval_both_worlds, .btb_flush_nop);
	dscac_asserts dscac_asserts_inst (.aclk, .aresetn, .psel(apb_bus.psel),
		.penable(apb_bus.penable), .pwrite(apb_bus.pwrite), .paddr(apb_bus.paddr),
		.paddr31(apb_bus.paddr31), .pready(apb_bus.pready), .halted, .halt_acknowledge,
		.resume_fetch, .precise_abort, .fault_status_update);

	initial
	begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// Debugger barrier answered by the halted core
	always @(posedge aclk)
	begin
		sync_barrier_done <= sync_barrier_req;
		cycles++;
		if (resume_fetch === 1'b1)
			resumes++;
		if (take_imprecise_abort === 1'b1)
			takes++;
		if (cycles == 5000)
		begin
			fails++;
			stop_test();
		end
	end

	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
		check("bresp", 32'(dscac_pkg::RESP_OKAY), 32'(bresp));
		@(posedge aclk);
	endtask

	task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		d = rdata;
		rready <= 1'b0;
		check("rresp", 32'(dscac_pkg::RESP_OKAY), 32'(rresp));
		@(posedge aclk);
	endtask

	// One debug register access through the controller
	task automatic apb(input logic wr, input logic [11:0] off, input logic [31:0] d);
		logic [31:0] st;
		int n;
		n = 0;
		axi_write(dscac_pkg::CTL_WDATA_OFF, d);
		axi_write(dscac_pkg::CTL_CMD_OFF, {18'h0, 1'b0, wr, off[11:2], 2'h0});
		do
		begin
			axi_read(dscac_pkg::CTL_STATUS_OFF, st);
			n++;
		end
		while (st[0] !== 1'b0 && n < 50);
		check("apb done", 32'h0, 32'(st[0]));
		last_err = st[1];
		axi_read(dscac_pkg::CTL_RDATA_OFF, q);
	endtask

	task automatic wait_halted(input logic v);
		int n;
		n = 0;
		while (halted !== v && n < 50)
		begin
			@(posedge aclk);
			n++;
		end
		check("halted", 32'(v), 32'(halted));
	endtask

	task automatic test_reset_and_map();
		apb(1'b0, dscac_pkg::STATUS_OFF, 32'h0);
		check("status reset", 32'h2, q);
		apb(1'b0, dscac_pkg::CACHE_OFF, 32'h0);
		check("cache reset", 32'(dscac_pkg::CACHE_RESET), 32'(q[2:0]));
		apb(1'b1, 12'hFFC, 32'h1);
		check("unmapped write err", 32'h1, 32'(last_err));
		apb(1'b0, 12'h100, 32'h0);
		check("unmapped read data", 32'h0, q);
	endtask

	task automatic test_halt_aborts();
		apb(1'b1, dscac_pkg::RUN_OFF, 32'h1);
		wait_halted(1'b1);
		check("ack", 32'h1, 32'(halt_acknowledge));
		precise_abort <= 1'b1;
		@(posedge aclk);
		precise_abort <= 1'b0;
		imprecise_abort <= 1'b1;
		@(posedge aclk);
		imprecise_abort <= 1'b0;
		apb(1'b0, dscac_pkg::STATUS_OFF, 32'h0);
		check("stickies", 32'hC3, 32'(q[7:0]));
		check("halted kept", 32'h1, 32'(halted));
		apb(1'b1, dscac_pkg::RUN_OFF, 32'h4);
		apb(1'b0, dscac_pkg::STATUS_OFF, 32'h0);
		check("stickies cleared", 32'h0, 32'(q[7:6]));
	endtask

	task automatic test_cache();
		apb(1'b1, dscac_pkg::CACHE_OFF, 32'h0);
		{alias_conflict, icache_inval_all, nonsecure, btb_flush, debug_access} <= 5'h1F;
		@(posedge aclk);
		@(posedge aclk);
		check("suppress", 32'h1, 32'(suppress_fill_evict));
		check("alias evict", 32'h1, 32'(evict_to_l2));
		check("write through", 32'h1, 32'(force_write_through));
		check("inval", 32'h1, 32'(icache_inval_do));
		check("both worlds", 32'h1, 32'(inval_both_worlds));
		check("btb nop", 32'h1, 32'(btb_flush_nop));
		check("hold", 32'h1, 32'(cache_state_hold));
		{alias_conflict, hash_conflict, debug_write, cache_hit} <= 4'h7;
		@(posedge aclk);
		@(posedge aclk);
		check("hash evict", 32'h1, 32'(evict_to_l2));
		check("write hit", 32'h0, 32'(cache_state_hold));
		{hash_conflict, icache_inval_all, nonsecure, btb_flush, debug_access} <= 5'h0;
		{debug_write, cache_hit} <= 2'h0;
		apb(1'b1, dscac_pkg::CACHE_OFF, 32'h5);
		check("suppress off", 32'h0, 32'(suppress_fill_evict));
		check("write back", 32'h0, 32'(force_write_through));
	endtask

	task automatic test_restart();
		apb(1'b1, dscac_pkg::RUN_OFF, 32'h2);
		repeat (4) @(posedge aclk);
		check("halted low", 32'h0, 32'(halted));
		check("ack low", 32'h0, 32'(halt_acknowledge));
		check("resumes", 32'h1, 32'(resumes));
		check("discarded", 32'h0, 32'(takes));
		apb(1'b0, dscac_pkg::STATUS_OFF, 32'h0);
		check("restarted", 32'h2, 32'(q[1:0]));
	endtask

	task automatic test_external();
		abort_mask <= 1'b1;
		entry_barrier_abort <= 1'b1;
		external_halt_request <= 1'b1;
		wait_halted(1'b1);
		external_halt_request <= 1'b0;
		entry_barrier_abort <= 1'b0;
		apb(1'b1, dscac_pkg::STATUS_OFF, 32'h800);
		apb(1'b0, dscac_pkg::STATUS_OFF, 32'h0);
		check("method", 32'(dscac_pkg::METHOD_EXTERNAL), 32'(q[5:2]));
		check("forced bit", 32'h1, 32'(q[dscac_pkg::ST_FORCED_ACK]));
		cross_trigger_restart <= 1'b1;
		wait_halted(1'b0);
		cross_trigger_restart <= 1'b0;
		repeat (3) @(posedge aclk);
		check("forced ack", 32'h1, 32'(halt_acknowledge));
		check("masked", 32'h0, 32'(takes));
		abort_mask <= 1'b0;
		repeat (4) @(posedge aclk);
		check("pending taken", 32'h1, 32'(takes));
	endtask

	task automatic test_watchpoint();
		{watchpoint_hit, imprecise_abort} <= 2'h3;
		@(posedge aclk);
		{watchpoint_hit, imprecise_abort} <= 2'h0;
		wait_halted(1'b1);
		imprecise_abort <= 1'b1;
		@(posedge aclk);
		imprecise_abort <= 1'b0;
		check("held on entry", 32'h1, 32'(takes));
		apb(1'b0, dscac_pkg::STATUS_OFF, 32'h0);
		check("watch method", 32'(dscac_pkg::METHOD_WATCH), 32'(q[5:2]));
		apb(1'b1, dscac_pkg::RUN_OFF, 32'h2);
		wait_halted(1'b0);
		repeat (4) @(posedge aclk);
		check("recorded taken once", 32'h2, 32'(takes));
	endtask

	initial
	begin
		{ce, aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wstrb} = '0;
		{wdata, fails, samples_checked, cycles, resumes, takes} = '0;
		{external_halt_request, cross_trigger_restart, watchpoint_hit, precise_abort} = 4'h0;
		{imprecise_abort, entry_barrier_abort, abort_mask, debug_access, debug_write} = 5'h0;
		{cache_hit, alias_conflict, hash_conflict, icache_inval_all, icache_inval_line} = 5'h0;
		{btb_flush, privileged, nonsecure} = 3'h0;
		ce = 1'b1;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		test_reset_and_map();
		test_halt_aborts();
		test_cache();
		test_restart();
		test_external();
		test_watchpoint();
		stop_test();
	end
endmodule
`default_nettype wire
